// [design/link_diag_pkg.sv]
/*
  Shared constants and carriers of the link diagnostics unit: management
  register offsets, field positions, reset values, timing counts and the
  packed structs of the management port and of the DSP and converter feed.
  Assumes a 100 MHz core clock and an 8 ns converter sample strobe.
*/
package link_diag_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TDR_SHORT_NS = 50;
  localparam int unsigned TDR_LONG_NS = 100;
  localparam logic [3:0] TDR_SHORT_CYC = 4'((TDR_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] TDR_LONG_CYC = 4'((TDR_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned VAR_UNIT_MS = 1;
  localparam int unsigned VAR_MS_CYCLES_DEFAULT = VAR_UNIT_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam logic [2:0] TDR_WIDTH_LONG_MIN = 3'h4;
  localparam logic [7:0] TDR_TIMER_LAST = 8'hFF;

  // ==========================================================
  // Register offsets
  localparam logic [4:0] ADDR_PHY_STATUS = 5'h10;
  localparam logic [4:0] ADDR_INT_CONTROL = 5'h11;
  localparam logic [4:0] ADDR_INT_STATUS_MASK = 5'h12;
  localparam logic [4:0] ADDR_CABLE_LENGTH = 5'h14;
  localparam logic [4:0] ADDR_FREQ_OFFSET = 5'h15;
  localparam logic [4:0] ADDR_TDR_CONTROL = 5'h16;
  localparam logic [4:0] ADDR_TDR_WINDOW = 5'h17;
  localparam logic [4:0] ADDR_TDR_PEAK = 5'h18;
  localparam logic [4:0] ADDR_TDR_THRESHOLD = 5'h19;
  localparam logic [4:0] ADDR_VAR_CONTROL = 5'h1A;
  localparam logic [4:0] ADDR_VAR_DATA = 5'h1B;
  localparam logic [4:0] ADDR_TDR_LEVEL = 5'h1C;
  localparam logic [4:0] ADDR_LQ_MONITOR = 5'h1D;
  localparam logic [4:0] ADDR_LQ_DATA = 5'h1E;

  // ==========================================================
  // Field positions
  localparam int unsigned BIT_LINK = 0;
  localparam int unsigned BIT_SPEED10 = 1;
  localparam int unsigned BIT_CROSSOVER = 14;
  localparam int unsigned BIT_INT_OE = 0;
  localparam int unsigned BIT_INT_EN = 1;
  localparam int unsigned BIT_LQ_MASK = 7;
  localparam int unsigned BIT_LQ_STATUS = 15;
  localparam int unsigned BIT_FREQ_SEL = 8;
  localparam int unsigned BIT_ENABLE = 15;
  localparam int unsigned BIT_TDR_100 = 14;
  localparam int unsigned BIT_TDR_TXPAIR = 13;
  localparam int unsigned BIT_TDR_RXPAIR = 12;
  localparam int unsigned BIT_TDR_SEND = 11;
  localparam int unsigned BIT_TDR_MIN = 7;
  localparam int unsigned BIT_LQ_WRITE = 14;
  localparam int unsigned BIT_LQ_SAMPLE = 13;
  localparam int unsigned BIT_LQ_HIGH = 8;
  localparam int unsigned BIT_VAR_READY = 0;
  localparam int unsigned NUM_PARAMS = 5;
  localparam logic [2:0] PARAM_AGC = 3'h1;

  // ==========================================================
  // Reset values
  localparam logic [4:0][7:0] THR_HIGH_RESET = {8'h7F, 8'h7F, 8'h7F, 8'hFF, 8'h7F};
  localparam logic [4:0][7:0] THR_LOW_RESET = {8'h80, 8'h80, 8'h80, 8'h00, 8'h80};
  localparam logic [7:0] WIN_START_RESET = 8'h00;
  localparam logic [7:0] WIN_STOP_RESET = 8'hFF;

  typedef enum logic [1:0] {
    TDR_IDLE = 2'b01,
    TDR_RUN = 2'b10
  } tdr_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [15:0] wdata;
  } mgmt_req_t;

  typedef struct packed {
    logic crossover;
    logic speed_100;
    logic link_valid;
    logic [7:0] cable_length;
    logic [7:0] eq_c1;
    logic [7:0] agc;
    logic [7:0] blw;
    logic [7:0] freq_offset;
    logic [7:0] freq_control;
    logic err_valid;
    logic [15:0] err_square;
  } dsp_feed_t;

  typedef struct packed {
    logic valid;
    logic [7:0] tx_pair;
    logic [7:0] rx_pair;
  } adc_feed_t;

endpackage : link_diag_pkg

// [design/link_diagnostics_unit.sv]
/*
  Link diagnostics unit of one 10/100 port: linked cable status, signal
  quality variance, link quality monitor with thresholds, and the
  reflectometry pulse generator and monitor.
  Assumes the management port, DSP feed and converter feed all come from
  logic on core_clk; diag_page says that the diagnostics page is selected.
*/
`timescale 1ns/1ps

// Notes on behaviour
// - Status bit 14 shows whether crossover pairs were chosen.
// - Cable length estimate reads valid only at 100 Mb with link.
// - Frequency register comes from clock recovery, valid at 100 Mb with link.
// - Frequency field shows long-term offset or current frequency control.
// - Variance period selects 2, 4, 6 or 8 ms.
// - 32-bit variance sum returned as two halves over consecutive reads.
// - Monitor warns when any watched DSP value leaves its window, only at 100 Mb with link.
// - Monitor register holds global enable and high/low warning per parameter.
// - Quality warning reaches interrupt only when control and mask enable it.
// - Sample bit captures the current adapted value of the chosen parameter.
// - Three-bit selector picks parameter, code 010 is baseline wander, low byte value.
// - Thresholds reached indirectly: write with strobe, read after writing address.
// - Warning only when value strictly exceeds threshold, never when equal.
// - After reset high thresholds are maxima and low thresholds minima.
// - Thresholds are signed 8-bit except adaptive gain, which is unsigned.
// - Pulse sent on either pair and response watched on either pair.
// - 10 Mb mode sends 50 ns or 100 ns link pulses.
// - 100 Mb mode sends 8 ns multiples up to 56 ns, alternating polarity.
// - Zero width sends no pulse but the monitor still runs.
// - Monitor tracks peak and threshold crossing, maxima or minima.
// - Peak and first crossing times recorded in 8 ns units.
// - Timer starts with the pulse; window limits the samples considered.
// - Window start and stop are 8-bit counts, reset 0 and 255.
// - Pulse width is a 3-bit count read per transmit mode.
// - Reading interrupt status clears all pending indications.
module link_diagnostics_unit #(
  parameter int unsigned VAR_MS_CYCLES = link_diag_pkg::VAR_MS_CYCLES_DEFAULT
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic diag_page,
  input wire link_diag_pkg::mgmt_req_t mgmt_req,
  output logic [15:0] mgmt_rdata,
  output logic mgmt_rvalid,
  input wire link_diag_pkg::dsp_feed_t dsp,
  input wire link_diag_pkg::adc_feed_t adc,
  output logic tdr_active,
  output logic tdr_send_rx_pair,
  output logic tdr_watch_rx_pair,
  output logic tdr_drive_10,
  output logic tdr_drive_pos,
  output logic tdr_drive_neg,
  output logic int_pin_out,
  output logic int_pin_oe_n
);
  import link_diag_pkg::*;

  typedef struct packed {
    logic int_oe;
    logic int_en;
    logic [7:0] int_mask;
    logic lq_pending;
    logic irq;
    logic freq_sel;
    logic var_en;
    logic [1:0] var_sel;
    logic var_ready;
    logic [19:0] var_cyc;
    logic [3:0] var_ms;
    logic [31:0] var_acc;
    logic [31:0] var_result;
    logic [15:0] var_hold;
    logic var_second;
    logic lq_en;
    logic [9:0] lq_warn;
    logic [2:0] lq_sel;
    logic lq_high;
    logic lq_sample_mode;
    logic [7:0] lq_sample;
    logic [4:0][7:0] thr_high;
    logic [4:0][7:0] thr_low;
    logic tdr_en;
    logic tdr_100;
    logic tdr_txp;
    logic tdr_rxp;
    logic [2:0] tdr_width;
    logic tdr_min;
    logic [7:0] tdr_level;
    logic [7:0] win_start;
    logic [7:0] win_stop;
    tdr_state_t tdr_state;
    logic [7:0] tdr_timer;
    logic [3:0] pulse_cnt;
    logic polarity;
    logic [2:0] drive;
    logic [7:0] peak_val;
    logic [7:0] peak_time;
    logic peak_seen;
    logic [7:0] thr_time;
    logic thr_seen;
    logic [15:0] rdata;
    logic rvalid;
  } state_t;

  state_t s;
  state_t next_s;

  function automatic logic beyond(input logic [7:0] a, input logic [7:0] b, input logic sgn);
    beyond = sgn ? ($signed(a) > $signed(b)) : (a > b);
  endfunction : beyond

  function automatic logic hits(input logic [7:0] a, input logic [7:0] b, input logic min_mode);
    hits = min_mode ? ($signed(a) < $signed(b)) : ($signed(a) > $signed(b));
  endfunction : hits

  // ==========================================================
  // Decode and live values
  logic wr_diag;
  logic rd_interrupt_status_mask;
  logic rd_link_quality_monitor_ctrl;
  logic rd_var;
  logic link100;
  logic [4:0][7:0] pv;
  logic [9:0] new_warn;
  logic [7:0] adc_sample;
  logic in_window;
  logic [7:0] freq_value;
  logic [7:0] thr_view;
  logic [3:0] var_target;
  logic [15:0] rd_value;

  always_comb begin
    wr_diag = mgmt_req.wr && diag_page;
    rd_interrupt_status_mask = mgmt_req.rd && mgmt_req.addr == ADDR_INT_STATUS_MASK;
    rd_link_quality_monitor_ctrl = mgmt_req.rd && diag_page && mgmt_req.addr == ADDR_LQ_MONITOR;
    rd_var = mgmt_req.rd && diag_page && mgmt_req.addr == ADDR_VAR_DATA;
    link100 = dsp.speed_100 && dsp.link_valid;
    pv = {dsp.freq_control, dsp.freq_offset, dsp.blw, dsp.agc, dsp.eq_c1};
    for (int i = 0; i < NUM_PARAMS; i++) begin
      new_warn[2 * i] = s.lq_en && link100 && beyond(s.thr_low[i], pv[i], i != PARAM_AGC);
      new_warn[2 * i + 1] = s.lq_en && link100 && beyond(pv[i], s.thr_high[i], i != PARAM_AGC);
    end
    adc_sample = s.tdr_rxp ? adc.rx_pair : adc.tx_pair;
    in_window = s.tdr_timer >= s.win_start && s.tdr_timer <= s.win_stop;
    freq_value = s.freq_sel ? dsp.freq_control : dsp.freq_offset;
    thr_view = 8'h00;
    if (s.lq_sel < 3'(NUM_PARAMS)) begin
      thr_view = s.lq_high ? s.thr_high[s.lq_sel] : s.thr_low[s.lq_sel];
    end
    // Period of 2, 4, 6 or 8 ms
    var_target = {1'b0, s.var_sel, 1'b0} + 4'h2;
  end

  // ==========================================================
  // Read multiplexer
  always_comb begin
    rd_value = 16'h0000;
    if (mgmt_req.addr == ADDR_PHY_STATUS) begin
      rd_value[BIT_CROSSOVER] = dsp.crossover;
      rd_value[BIT_LINK] = dsp.link_valid;
      rd_value[BIT_SPEED10] = !dsp.speed_100;
    end else if (mgmt_req.addr == ADDR_INT_CONTROL) begin
      rd_value[BIT_INT_OE] = s.int_oe;
      rd_value[BIT_INT_EN] = s.int_en;
    end else if (mgmt_req.addr == ADDR_INT_STATUS_MASK) begin
      rd_value[7:0] = s.int_mask;
      rd_value[BIT_LQ_STATUS] = s.lq_pending;
    end else if (diag_page) begin
      unique case (mgmt_req.addr)
        ADDR_CABLE_LENGTH: begin
          // Valid only at 100 Mb with link
          rd_value[7:0] = link100 ? dsp.cable_length : 8'h00;
        end
        ADDR_FREQ_OFFSET: begin
          // Valid only at 100 Mb with link
          rd_value[7:0] = link100 ? freq_value : 8'h00;
          rd_value[BIT_FREQ_SEL] = s.freq_sel;
        end
        ADDR_TDR_CONTROL: begin
          rd_value = {s.tdr_en, s.tdr_100, s.tdr_txp, s.tdr_rxp, s.tdr_state == TDR_RUN,
                      s.tdr_width, s.tdr_min, 7'h00};
        end
        ADDR_TDR_WINDOW: rd_value = {s.win_start, s.win_stop};
        ADDR_TDR_PEAK: rd_value = {s.peak_time, s.peak_val};
        ADDR_TDR_THRESHOLD: rd_value = {s.thr_seen, 7'h00, s.thr_time};
        ADDR_TDR_LEVEL: rd_value[7:0] = s.tdr_level;
        ADDR_VAR_CONTROL: begin
          rd_value[BIT_ENABLE] = s.var_en;
          rd_value[2:1] = s.var_sel;
          rd_value[BIT_VAR_READY] = s.var_ready;
        end
        ADDR_VAR_DATA: begin
          // Low half first, high half held
          rd_value = s.var_second ? s.var_hold : s.var_result[15:0];
        end
        ADDR_LQ_MONITOR: begin
          rd_value[BIT_ENABLE] = s.lq_en;
          rd_value[9:0] = s.lq_warn;
        end
        ADDR_LQ_DATA: begin
          rd_value = {2'b00, s.lq_sample_mode, 1'b0, s.lq_sel, s.lq_high,
                      s.lq_sample_mode ? s.lq_sample : thr_view};
        end
        default: rd_value = 16'h0000;
      endcase
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    next_s = s;
    next_s.rvalid = mgmt_req.rd;
    if (mgmt_req.rd) begin
      next_s.rdata = rd_value;
    end

    // Interrupt control and mask
    if (mgmt_req.wr && mgmt_req.addr == ADDR_INT_CONTROL) begin
      next_s.int_oe = mgmt_req.wdata[BIT_INT_OE];
      next_s.int_en = mgmt_req.wdata[BIT_INT_EN];
    end
    if (mgmt_req.wr && mgmt_req.addr == ADDR_INT_STATUS_MASK) begin
      next_s.int_mask = mgmt_req.wdata[7:0];
    end
    // Status read clears, new event wins
    next_s.lq_pending = (rd_interrupt_status_mask ? 1'b0 : s.lq_pending) | (|(new_warn & ~s.lq_warn));
    next_s.irq = s.int_en && s.int_mask[BIT_LQ_MASK] && s.lq_pending;

    next_s.lq_warn = (rd_link_quality_monitor_ctrl ? 10'h000 : s.lq_warn) | new_warn;

    if (wr_diag) begin
      unique case (mgmt_req.addr)
        ADDR_FREQ_OFFSET: next_s.freq_sel = mgmt_req.wdata[BIT_FREQ_SEL];
        ADDR_VAR_CONTROL: begin
          next_s.var_en = mgmt_req.wdata[BIT_ENABLE];
          next_s.var_sel = mgmt_req.wdata[2:1];
          next_s.var_cyc = 20'h0_0000;
          next_s.var_ms = 4'h0;
          next_s.var_acc = 32'h0000_0000;
        end
        ADDR_LQ_MONITOR: next_s.lq_en = mgmt_req.wdata[BIT_ENABLE];
        ADDR_LQ_DATA: begin
          next_s.lq_sel = mgmt_req.wdata[11:9];
          next_s.lq_high = mgmt_req.wdata[BIT_LQ_HIGH];
          next_s.lq_sample_mode = mgmt_req.wdata[BIT_LQ_SAMPLE];
          if (mgmt_req.wdata[BIT_LQ_SAMPLE] && mgmt_req.wdata[11:9] < 3'(NUM_PARAMS)) begin
            next_s.lq_sample = pv[mgmt_req.wdata[11:9]];
          end
          if (mgmt_req.wdata[BIT_LQ_WRITE] && mgmt_req.wdata[11:9] < 3'(NUM_PARAMS)) begin
            if (mgmt_req.wdata[BIT_LQ_HIGH]) begin
              next_s.thr_high[mgmt_req.wdata[11:9]] = mgmt_req.wdata[7:0];
            end else begin
              next_s.thr_low[mgmt_req.wdata[11:9]] = mgmt_req.wdata[7:0];
            end
          end
        end
        ADDR_TDR_CONTROL: begin
          next_s.tdr_en = mgmt_req.wdata[BIT_ENABLE];
          next_s.tdr_100 = mgmt_req.wdata[BIT_TDR_100];
          next_s.tdr_txp = mgmt_req.wdata[BIT_TDR_TXPAIR];
          next_s.tdr_rxp = mgmt_req.wdata[BIT_TDR_RXPAIR];
          next_s.tdr_width = mgmt_req.wdata[10:8];
          next_s.tdr_min = mgmt_req.wdata[BIT_TDR_MIN];
        end
        ADDR_TDR_WINDOW: {next_s.win_start, next_s.win_stop} = mgmt_req.wdata;
        ADDR_TDR_LEVEL: next_s.tdr_level = mgmt_req.wdata[7:0];
        default: begin
        end
      endcase
    end

    // Two reads pair into one sum; a period end below wins
    if (rd_var) begin
      next_s.var_second = !s.var_second;
      if (!s.var_second) begin
        next_s.var_hold = s.var_result[31:16];
      end else begin
        next_s.var_ready = 1'b0;
      end
    end

    // Variance accumulation
    if (s.var_en && !(wr_diag && mgmt_req.addr == ADDR_VAR_CONTROL)) begin
      if (dsp.err_valid) begin
        next_s.var_acc = s.var_acc + {16'h0000, dsp.err_square};
      end
      next_s.var_cyc = s.var_cyc + 20'h0_0001;
      if (s.var_cyc == 20'(VAR_MS_CYCLES - 1)) begin
        next_s.var_cyc = 20'h0_0000;
        next_s.var_ms = s.var_ms + 4'h1;
        if (s.var_ms + 4'h1 == var_target) begin
          next_s.var_ms = 4'h0;
          next_s.var_result = dsp.err_valid ? s.var_acc + {16'h0000, dsp.err_square}
                                            : s.var_acc;
          next_s.var_acc = 32'h0000_0000;
          next_s.var_ready = 1'b1;
        end
      end
    end
    // Reflectometry sequencer
    next_s.drive = 3'b000;
    unique case (s.tdr_state)
      TDR_IDLE: begin
        if (wr_diag && mgmt_req.addr == ADDR_TDR_CONTROL && mgmt_req.wdata[BIT_ENABLE]
            && mgmt_req.wdata[BIT_TDR_SEND]) begin
          next_s.tdr_state = TDR_RUN;
          next_s.tdr_timer = 8'h00;
          next_s.peak_seen = 1'b0;
          next_s.thr_seen = 1'b0;
          next_s.peak_val = 8'h00;
          next_s.peak_time = 8'h00;
          next_s.thr_time = 8'h00;
          if (mgmt_req.wdata[10:8] == 3'h0) begin
            next_s.pulse_cnt = 4'h0;
          end else if (mgmt_req.wdata[BIT_TDR_100]) begin
            // 8 ns steps up to 56 ns
            next_s.pulse_cnt = {1'b0, mgmt_req.wdata[10:8]};
            next_s.polarity = !s.polarity;
          end else begin
            next_s.pulse_cnt = mgmt_req.wdata[10:8] < TDR_WIDTH_LONG_MIN ? TDR_SHORT_CYC
                                                                          : TDR_LONG_CYC;
          end
        end
      end
      TDR_RUN: begin
        if (s.pulse_cnt != 4'h0) begin
          next_s.drive = s.tdr_100 ? {1'b0, s.polarity, !s.polarity} : 3'b100;
          if (!s.tdr_100 || adc.valid) begin
            next_s.pulse_cnt = s.pulse_cnt - 4'h1;
          end
        end
        if (adc.valid) begin
          if (in_window) begin
            if (!s.peak_seen || hits(adc_sample, s.peak_val, s.tdr_min)) begin
              next_s.peak_seen = 1'b1;
              next_s.peak_val = adc_sample;
              next_s.peak_time = s.tdr_timer;
            end
            if (!s.thr_seen && hits(adc_sample, s.tdr_level, s.tdr_min)) begin
              next_s.thr_seen = 1'b1;
              next_s.thr_time = s.tdr_timer;
            end
          end
          next_s.tdr_timer = s.tdr_timer + 8'h01;
          if (s.tdr_timer == TDR_TIMER_LAST) begin
            next_s.tdr_state = TDR_IDLE;
          end
        end
        if (!s.tdr_en) begin
          next_s.tdr_state = TDR_IDLE;
          next_s.pulse_cnt = 4'h0;
          next_s.drive = 3'b000;
        end
      end
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
      s.thr_high <= THR_HIGH_RESET;
      s.thr_low <= THR_LOW_RESET;
      s.win_start <= WIN_START_RESET;
      s.win_stop <= WIN_STOP_RESET;
      s.tdr_state <= TDR_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs
  always_comb begin
    mgmt_rdata = s.rdata;
    mgmt_rvalid = s.rvalid;
    tdr_active = s.tdr_en;
    tdr_send_rx_pair = s.tdr_txp;
    tdr_watch_rx_pair = s.tdr_rxp;
    tdr_drive_10 = s.drive[2];
    tdr_drive_pos = s.drive[0];
    tdr_drive_neg = s.drive[1];
    int_pin_out = 1'b0;
    int_pin_oe_n = !(s.int_oe && s.irq);
  end

endmodule : link_diagnostics_unit

// [testbench/cable_link_model.sv]
/*
  Far side of the link: holds the adapted DSP values given by the bench,
  sends one variance term each cycle and a converter sample each cycle.
  Assumes core_clk and reset_n of the unit under test.
*/
`timescale 1ns/1ps
module cable_link_model (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire link_diag_pkg::dsp_feed_t cfg,
  output link_diag_pkg::dsp_feed_t dsp,
  output link_diag_pkg::adc_feed_t adc
);
  import link_diag_pkg::*;
  logic [7:0] cnt;
  logic hit;
  // ==========================================================
  // Echo counter, plateau at counts 100 to 103
  assign hit = (cnt >= 8'h64) && (cnt <= 8'h67);
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)
      cnt <= 8'h00;
    else
      cnt <= cnt + 8'h01;
  end
  always_comb begin
    dsp = cfg;
    dsp.err_valid = reset_n;
    adc = '{valid: reset_n, tx_pair: hit ? 8'hD0 : 8'h00, rx_pair: hit ? 8'h50 : 8'h00};
  end
endmodule : cable_link_model

// [testbench/link_diag_properties.sv]
/*
  Port checker of the link diagnostics unit, bound to its top module.
  Assumes one clock domain and reset_n active low.
*/
`timescale 1ns/1ps
module link_diag_properties #(
  parameter int unsigned VAR_MS_CYCLES = 20
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic diag_page,
  input wire link_diag_pkg::mgmt_req_t mgmt_req,
  input wire logic [15:0] mgmt_rdata,
  input wire logic mgmt_rvalid,
  input wire link_diag_pkg::dsp_feed_t dsp,
  input wire link_diag_pkg::adc_feed_t adc,
  input wire logic tdr_active,
  input wire logic tdr_send_rx_pair,
  input wire logic tdr_watch_rx_pair,
  input wire logic tdr_drive_10,
  input wire logic tdr_drive_pos,
  input wire logic tdr_drive_neg,
  input wire logic int_pin_out,
  input wire logic int_pin_oe_n
);
  import link_diag_pkg::*;
  logic on100;
  logic drv;
  assign on100 = dsp.speed_100 && dsp.link_valid;
  assign drv = tdr_drive_pos || tdr_drive_neg || tdr_drive_10;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // Assertions
  read_answer_a: assert property (mgmt_req.rd |=> mgmt_rvalid)
    else $error("read not answered");
  answer_cause_a: assert property (mgmt_rvalid |-> $past(mgmt_req.rd))
    else $error("answer without read");
  crossover_bit_a: assert property (mgmt_req.rd && mgmt_req.addr == ADDR_PHY_STATUS
    |=> mgmt_rdata[14] == $past(dsp.crossover)) else $error("crossover bit wrong");
  length_gate_a: assert property (mgmt_req.rd && mgmt_req.addr == ADDR_CABLE_LENGTH
    && !on100 |=> mgmt_rdata == 16'h0000) else $error("length not gated");
  length_value_a: assert property (mgmt_req.rd && mgmt_req.addr == ADDR_CABLE_LENGTH
    && diag_page && on100 |=> mgmt_rdata[7:0] == $past(dsp.cable_length))
    else $error("length value wrong");
  freq_gate_a: assert property (mgmt_req.rd && mgmt_req.addr == ADDR_FREQ_OFFSET
    && !on100 |=> mgmt_rdata[7:0] == 8'h00) else $error("frequency not gated");
  polarity_excl_a: assert property (!(tdr_drive_pos && tdr_drive_neg))
    else $error("both polarities driven");
  pulse_ten_a: assert property ($rose(tdr_drive_10) |-> tdr_drive_10 [*5])
    else $error("short link pulse");
  pulse_end_a: assert property ($rose(tdr_drive_10) |-> ##[5:10] !tdr_drive_10)
    else $error("long link pulse");
  drive_gate_a: assert property (!tdr_active && !$past(tdr_active) |-> !drv)
    else $error("drive while disabled");
  pin_level_a: assert property (!int_pin_oe_n |-> !int_pin_out)
    else $error("interrupt pin not low");
  // ==========================================================
  // Covers
  c_neg: cover property ($rose(tdr_drive_neg));
  c_ten: cover property ($rose(tdr_drive_10));
  c_irq: cover property ($fell(int_pin_oe_n));
endmodule : link_diag_properties

bind link_diagnostics_unit link_diag_properties #(.VAR_MS_CYCLES(VAR_MS_CYCLES))
  i_link_diag_properties (.core_clk, .reset_n, .diag_page, .mgmt_req, .mgmt_rdata,
  .mgmt_rvalid, .dsp, .adc, .tdr_active, .tdr_send_rx_pair, .tdr_watch_rx_pair,
  .tdr_drive_10, .tdr_drive_pos, .tdr_drive_neg, .int_pin_out, .int_pin_oe_n);

// [testbench/link_diagnostics_unit_tb.sv]
/*
  Register-level bench of the link diagnostics unit with a cable model.
  Assumes the unit is built with VAR_MS_CYCLES of 20.
*/
`timescale 1ns/1ps
module link_diagnostics_unit_tb;
  import link_diag_pkg::*;
  logic core_clk, reset_n, diag_page, rvalid, act, srx, wrx, d10, dp, dn, ipo, ioe;
  mgmt_req_t q;
  dsp_feed_t cfg, dsp;
  adc_feed_t adc;
  logic [15:0] rdata, d, pt;
  int fail_count = 0, checked = 0, cyc = 0, np = 0, nn = 0, n10 = 0;
  logic [15:0] ctl [5] = '{16'hFB00, 16'hCB80, 16'h8C00, 16'hC800, 16'hFB00};
  int ex [5][5] = '{'{0, 3, 0, 'h50, 1}, '{3, 0, 0, 'hD0, 1}, '{0, 0, 10, 0, 0}, '{0, 0, 0, 0, 0},
    '{0, 3, 0, 0, 0}};
  link_diagnostics_unit #(.VAR_MS_CYCLES(20)) i_link_diagnostics_unit (.core_clk, .reset_n,
    .diag_page, .mgmt_req(q), .mgmt_rdata(rdata), .mgmt_rvalid(rvalid), .dsp, .adc,
    .tdr_active(act), .tdr_send_rx_pair(srx), .tdr_watch_rx_pair(wrx), .tdr_drive_10(d10),
    .tdr_drive_pos(dp), .tdr_drive_neg(dn), .int_pin_out(ipo), .int_pin_oe_n(ioe));
  cable_link_model i_cable_link_model (.core_clk, .reset_n, .cfg, .dsp, .adc);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    np <= np + int'(dp);
    nn <= nn + int'(dn);
    n10 <= n10 + int'(d10);
    if (cyc == 6000) begin
      fail_count++;
      results();
    end
  end
  // ==========================================================
  // Tasks
  task automatic chk(input logic [15:0] g, e, m);
    checked++;
    if ((g & m) !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g & m, e);
    end
  endtask : chk
  task automatic chkr(input logic [15:0] g, lo, hi);
    checked++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      fail_count++;
      $display("[ERR] %0t sum %h out of range", $time, g);
    end
  endtask : chkr
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(negedge core_clk);
    q = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(negedge core_clk);
    q.wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a);
    @(negedge core_clk);
    q = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(negedge core_clk);
    q.rd = 1'b0;
    d = rdata;
    chk(16'(rvalid), 16'h0001, 16'h0001);
  endtask : rd
  task automatic results();
    if (fail_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results
  // ==========================================================
  // Sequence
  initial begin
    reset_n = 1'b0;
    diag_page = 1'b1;
    q = '0;
    cfg = '{1'b1, 1'b1, 1'b1, 8'h2A, 8'h05, 8'h90, 8'h12, 8'hF3, 8'h0C, 1'b0, 16'h0003};
    repeat (8) @(posedge core_clk);
    @(negedge core_clk) reset_n = 1'b1;
    rd(ADDR_TDR_WINDOW); chk(d, 16'h00FF, 16'hFFFF); // window
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_LQ_DATA, 16'(i << 9) | 16'h0100);
      rd(ADDR_LQ_DATA); chk(d, (i == 1) ? 16'h00FF : 16'h007F, 16'h00FF); // high
      wr(ADDR_LQ_DATA, 16'(i << 9));
      rd(ADDR_LQ_DATA); chk(d, (i == 1) ? 16'h0000 : 16'h0080, 16'h00FF); // low
    end
    rd(ADDR_PHY_STATUS); chk(d, 16'h4000, 16'h4000); // crossover
    rd(ADDR_CABLE_LENGTH); chk(d, 16'h002A, 16'h00FF); // length
    wr(ADDR_FREQ_OFFSET, 16'h0000);
    rd(ADDR_FREQ_OFFSET); chk(d, 16'h00F3, 16'h00FF); // offset
    wr(ADDR_FREQ_OFFSET, 16'h0100);
    rd(ADDR_FREQ_OFFSET); chk(d, 16'h000C, 16'h00FF); // control
    wr(ADDR_LQ_DATA, 16'h2400);
    rd(ADDR_LQ_DATA); chk(d, 16'h0012, 16'h00FF); // sample
    cfg.link_valid = 1'b0;
    rd(ADDR_CABLE_LENGTH); chk(d, 16'h0000, 16'hFFFF); // no link
    rd(ADDR_FREQ_OFFSET); chk(d, 16'h0000, 16'h00FF); // no link
    cfg.link_valid = 1'b1;
    wr(ADDR_INT_CONTROL, 16'h0003);
    wr(ADDR_INT_STATUS_MASK, 16'h0080);
    wr(ADDR_LQ_DATA, 16'h4512);
    wr(ADDR_LQ_MONITOR, 16'h8000);
    rd(ADDR_LQ_MONITOR); chk(d, 16'h8000, 16'h83FF); // equal
    wr(ADDR_LQ_DATA, 16'h4511);
    wr(ADDR_LQ_DATA, 16'h457F);
    rd(ADDR_LQ_MONITOR); chk(d, 16'h8020, 16'h83FF); // held
    chk(16'(ioe), 16'h0000, 16'h0001); // pin on
    chk(16'(ipo), 16'h0000, 16'h0001); // pin level
    rd(ADDR_LQ_MONITOR); chk(d, 16'h8000, 16'h83FF); // read clears
    rd(ADDR_INT_STATUS_MASK); chk(d, 16'h8080, 16'h80FF); // pending
    rd(ADDR_INT_STATUS_MASK); chk(d, 16'h0000, 16'h8000); // cleared
    chk(16'(ioe), 16'h0001, 16'h0001); // pin off
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_VAR_CONTROL, 16'h8000 | 16'(s << 1));
      d = 16'h0000;
      for (int k = 0; k < 100 && d[0] !== 1'b1; k++) rd(ADDR_VAR_CONTROL);
      rd(ADDR_VAR_DATA); chkr(d, 16'(120 * s + 114), 16'(120 * s + 126)); // period
      rd(ADDR_VAR_DATA); chk(d, 16'h0000, 16'hFFFF); // high half
      rd(ADDR_VAR_CONTROL); chk(d, 16'h0000, 16'h0001); // ready off
    end
    wr(ADDR_TDR_LEVEL, 16'h0040);
    for (int r = 0; r < 5; r++) begin
      if (r == 4) begin
        wr(ADDR_TDR_WINDOW, 16'h0100);
        rd(ADDR_TDR_WINDOW); chk(d, 16'h0100, 16'hFFFF); // window write
      end
      @(negedge core_clk);
      {np, nn, n10} = '0;
      wr(ADDR_TDR_CONTROL, ctl[r]);
      chk(16'({act, srx, wrx}), 16'({1'b1, ctl[r][13:12]}), 16'h0007); // pair select
      d = 16'h0800;
      for (int k = 0; k < 200 && d[11] !== 1'b0; k++) rd(ADDR_TDR_CONTROL);
      chk(16'(np), 16'(ex[r][0]), 16'hFFFF); // positive
      chk(16'(nn), 16'(ex[r][1]), 16'hFFFF); // negative
      chk(16'(n10), 16'(ex[r][2]), 16'hFFFF); // link pulse
      rd(ADDR_TDR_PEAK); chk(d, 16'(ex[r][3]), 16'h00FF); // peak
      pt = d >> 8;
      rd(ADDR_TDR_THRESHOLD); chk(d, 16'(ex[r][4]) << 15, 16'h8000); // crossing
      if (r == 0) chk(d, pt, 16'h00FF); // first time
    end
    results();
  end
endmodule : link_diagnostics_unit_tb
